// [shared/prsd_pkg.sv]
// ----------------------------------------------------------------------
// Protection status and debug register block: shared definitions
// ----------------------------------------------------------------------
package prsd_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] ADDR_CAPS    = 8'hA0;
  localparam logic [7:0] ADDR_TOPO_LO = 8'hA1;
  localparam logic [7:0] ADDR_TOPO_HI = 8'hA2;
  localparam logic [7:0] ADDR_KEY     = 8'hA3;
  localparam logic [7:0] ADDR_DBG     = 8'hC0;

  // Reset values
  localparam logic [7:0] CAPS_RESET    = 8'h13;
  localparam logic [7:0] TOPO_LO_RESET = 8'h00;
  localparam logic [7:0] TOPO_HI_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET     = 8'h00;
  localparam logic [7:0] DBG_RESET     = 8'h00;

  // Field positions
  localparam int CAPS_REPEATER_BIT    = 6;
  localparam int CAPS_LIST_READY_BIT  = 5;
  localparam int CAPS_FAST_BUS_BIT    = 4;
  localparam int CAPS_FEATURES_BIT    = 1;
  localparam int CAPS_CLEAR_REAUTH    = 0;
  localparam int TOPO_MAX_DEV_BIT     = 7;
  localparam int TOPO_MAX_CASC_BIT    = 3;
  localparam int DBG_CHKSUM_BIT       = 3;
  localparam int DBG_FAST_LINK_VERIFY_BIT      = 2;
  localparam int DBG_TIMER_BIT        = 1;
  localparam int DBG_MASTER_FAST_BIT  = 0;
  localparam int IND_MASTER_FAST_BIT  = 0;
  localparam logic [7:0] DBG_WRITE_MASK = 8'h0F;

  // Verification periods in frames
  localparam logic [7:0] FAST_FRAME_VERIFY_FRAMES = 8'h02;
  localparam logic [7:0] FAST_LINK_CHECK_FRAMES   = 8'h10;
  localparam logic [7:0] SLOW_FRAME_VERIFY_FRAMES = 8'h10;
  localparam logic [7:0] SLOW_LINK_CHECK_FRAMES   = 8'h80;

  // Key list geometry
  localparam logic [6:0] KEY_LIST_DEVICES = 7'h10;
  localparam int         KEY_BYTES_PER_DEV = 5;
  localparam int         KEY_LIST_BYTES    = 80;
  localparam int         KEY_PTR_W         = 7;

  // Receiver status as delivered over the link
  typedef struct packed {
    logic       repeater;
    logic       list_ready;
    logic       fast_bus;
    logic       features;
    logic       clear_reauth;
    logic       max_dev;
    logic [6:0] dev_count;
    logic       max_casc;
    logic [2:0] casc_depth;
  } prsd_rx_status_t;

  // One pixel, three colour channels
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } prsd_pixel_t;

  // Line checksum sequencer; one bit changes per step except CK_SEND back to CK_IDLE
  typedef enum logic [1:0] {
    CK_IDLE = 2'b00,
    CK_LINE = 2'b01,
    CK_SEND = 2'b11
  } prsd_ck_state_t;

endpackage

// [logic/prsd_key_store.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Key list byte store with a read position
// ----------------------------------------------------------------------
module prsd_key_store
  import prsd_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 list_start,
  input  wire logic                 wr_valid,
  input  wire logic [7:0]           wr_byte,
  input  wire logic                 rd_advance,
  output logic      [7:0]           rd_byte,
  output logic      [KEY_PTR_W-1:0] rd_ptr
);

  logic [7:0]           mem [KEY_LIST_BYTES]; // List bytes, not reset
  logic [KEY_PTR_W-1:0] wr_ptr;               // Next byte to fill

  // Fill position restarts with each new list
  always_ff @(posedge ref_clk) begin
    if (reset || list_start) begin
      wr_ptr <= '0;
    end else if (wr_valid && (32'(wr_ptr) < KEY_LIST_BYTES)) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Store bytes; overflow beyond the list depth is dropped
  always_ff @(posedge ref_clk) begin
    if (wr_valid && !list_start && (32'(wr_ptr) < KEY_LIST_BYTES)) begin
      mem[wr_ptr] <= wr_byte;
    end
  end

  // Read position: one byte per completed read, restart on new list
  always_ff @(posedge ref_clk) begin
    if (reset || list_start) begin
      rd_ptr <= '0;
    end else if (rd_advance && (32'(rd_ptr) < KEY_LIST_BYTES)) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Unfilled or past-end positions read as zero
  assign rd_byte = (rd_ptr < wr_ptr) ? mem[rd_ptr] : KEY_RESET;

  chk_list_restart: assert property (@(posedge ref_clk) disable iff (reset)
    list_start |=> rd_ptr == '0)
    else $error("key read position not restarted");

endmodule

// [logic/prsd_verify_sched.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Frame verification and link integrity schedule
// ----------------------------------------------------------------------
module prsd_verify_sched
  import prsd_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic fast,
  input  wire logic frame_start,
  output logic      frame_verify_due,
  output logic      link_integrity_due
);

  logic [7:0] fv_cnt;    // Frames since last verify
  logic [7:0] li_cnt;    // Frames since last integrity check
  logic [7:0] fv_period; // Current verify period
  logic [7:0] li_period; // Current integrity period

  // Period chosen by the fast verification bit
  assign fv_period = fast ? FAST_FRAME_VERIFY_FRAMES : SLOW_FRAME_VERIFY_FRAMES;
  assign li_period = fast ? FAST_LINK_CHECK_FRAMES : SLOW_LINK_CHECK_FRAMES;

  // Compare with >= so a switch to the short period never stalls
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fv_cnt           <= '0;
      frame_verify_due <= 1'b0;
    end else begin
      frame_verify_due <= 1'b0;
      if (frame_start) begin
        if (fv_cnt >= fv_period - 8'h01) begin
          fv_cnt           <= '0;
          frame_verify_due <= 1'b1;
        end else begin
          fv_cnt <= fv_cnt + 8'h01;
        end
      end
    end
  end

  // Integrity counter, same scheme
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      li_cnt             <= '0;
      link_integrity_due <= 1'b0;
    end else begin
      link_integrity_due <= 1'b0;
      if (frame_start) begin
        if (li_cnt >= li_period - 8'h01) begin
          li_cnt             <= '0;
          link_integrity_due <= 1'b1;
        end else begin
          li_cnt <= li_cnt + 8'h01;
        end
      end
    end
  end

  chk_fast_verify: assert property (@(posedge ref_clk) disable iff (reset)
    fast && frame_start && fv_cnt == 8'h01 |=> frame_verify_due)
    else $error("fast frame verify not due after 2 frames");

  chk_slow_integrity: assert property (@(posedge ref_clk) disable iff (reset)
    !fast && frame_start && li_cnt == 8'h7F |=> link_integrity_due)
    else $error("slow integrity check not due after 128 frames");

endmodule

// [logic/prsd_status_regs.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Receiver protection status mirror and debug control registers
// ----------------------------------------------------------------------

// Notes on behaviour
// - Bit 6 shows receiver repeater capability
// - Bit 5 shows key list ready
// - Bit 4 fast bus claim, logic ignores
// - Bit 1 shows enhanced feature support
// - Bit 0 shows clear video during reauth
// - Topology error when devices exceed list depth
// - Seven-bit device count, zero for non-repeater
// - Topology error beyond seven cascade levels
// - Three-bit cascade depth field
// - Key port read returns next list byte
// - Debug bit 3 sends per-line channel checksums
// - Fast verify: every 2 and 16 frames
// - Normal verify: every 16 and 128 frames
// - Debug bit 1 speeds authentication timers
// - Debug bit 0 selects master fast timing
// - Master fast bit mirrored in indirect status
module prsd_status_regs
  import prsd_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  output logic                 reg_rvalid,
  input  wire logic            status_valid,
  input  wire prsd_rx_status_t status_in,
  input  wire logic            key_list_start,
  input  wire logic            key_byte_valid,
  input  wire logic [7:0]      key_byte,
  input  wire logic            frame_start,
  input  wire logic            video_de,
  input  wire prsd_pixel_t     video_pixel,
  output logic                 checksum_valid,
  output prsd_pixel_t          checksum_out,
  output logic                 frame_verify_due,
  output logic                 link_integrity_due,
  output logic                 auth_timer_speedup,
  output logic                 protect_master_fast_timing,
  output logic      [7:0]      indirect_status_reg
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]           rx_capability;         // Mirrored capability
  logic [7:0]           rx_topology_status_lo; // Device count and flag
  logic [7:0]           rx_topology_status_hi; // Cascade depth and flag
  logic [7:0]           protection_debug_ctrl; // Debug controls
  logic [7:0]           key_rd_byte;           // Byte at read position
  logic [KEY_PTR_W-1:0] key_rd_ptr;            // Key read position
  logic                 key_rd_hit;            // Read of the key port
  logic                 line_checksum_enable;  // Debug bit 3
  logic                 fast_link_verify;      // Debug bit 2
  logic [7:0]           next_rdata;            // Read mux result
  logic                 sched_fv;              // Scheduler verify pulse
  logic                 sched_li;              // Scheduler integrity pulse
  prsd_ck_state_t       ck_state;              // Checksum sequencer
  prsd_ck_state_t       next_ck_state;         // Its next value
  logic [2:0][7:0]      ck_acc;                // Running channel sums
  logic [2:0][7:0]      pix_ch;                // Pixel split by channel

  assign line_checksum_enable = protection_debug_ctrl[DBG_CHKSUM_BIT];
  assign fast_link_verify     = protection_debug_ctrl[DBG_FAST_LINK_VERIFY_BIT];
  assign key_rd_hit           = reg_rd && (reg_addr == ADDR_KEY);
  assign pix_ch               = {video_pixel.red, video_pixel.green, video_pixel.blue};

  // Ones-complement add: carry out wraps back into bit 0
  function automatic logic [7:0] ones_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] sum;
    sum      = {1'b0, a} + {1'b0, b};
    ones_add = sum[7:0] + {7'h00, sum[8]};
  endfunction

  // ----------------------------------------------------------------------
  // Receiver status mirror
  // ----------------------------------------------------------------------

  // Capability bits follow each status update from the link.
  // Host writes never reach here, so the mirror stays read-only.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_capability <= CAPS_RESET;
    end else if (status_valid) begin
      rx_capability                      <= 8'h00;
      // Meaningful only once the receiver key is ready
      rx_capability[CAPS_REPEATER_BIT]   <= status_in.repeater;
      rx_capability[CAPS_LIST_READY_BIT] <= status_in.list_ready;
      // Shown for software only; bus traffic rides the link anyway
      rx_capability[CAPS_FAST_BUS_BIT]   <= status_in.fast_bus;
      rx_capability[CAPS_FEATURES_BIT]   <= status_in.features;
      rx_capability[CAPS_CLEAR_REAUTH]   <= status_in.clear_reauth;
    end
  end

  // Device count and overflow flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_topology_status_lo <= TOPO_LO_RESET;
    end else if (status_valid) begin
      // Local depth check backs up the flag the receiver sends
      rx_topology_status_lo[TOPO_MAX_DEV_BIT] <= status_in.max_dev ||
          (status_in.repeater && (status_in.dev_count > KEY_LIST_DEVICES));
      // A plain receiver has nothing downstream
      rx_topology_status_lo[6:0] <= status_in.repeater ? status_in.dev_count : 7'h00;
    end
  end

  // Cascade depth and flag; upper nibble reserved
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_topology_status_hi <= TOPO_HI_RESET;
    end else if (status_valid) begin
      rx_topology_status_hi                    <= 8'h00;
      rx_topology_status_hi[TOPO_MAX_CASC_BIT] <= status_in.max_casc;
      rx_topology_status_hi[2:0]               <= status_in.casc_depth;
    end
  end

  // ----------------------------------------------------------------------
  // Key list store
  // ----------------------------------------------------------------------

  // Position advances only on a read of the key port, never on a write; a new list restarts it
  prsd_key_store u_key_store (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .list_start (key_list_start),
    .wr_valid   (key_byte_valid),
    .wr_byte    (key_byte),
    .rd_advance (key_rd_hit),
    .rd_byte    (key_rd_byte),
    .rd_ptr     (key_rd_ptr)
  );

  // ----------------------------------------------------------------------
  // Debug control register
  // ----------------------------------------------------------------------

  // Only the four low bits are writable; the rest stay zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      protection_debug_ctrl <= DBG_RESET;
    end else if (reg_wr && (reg_addr == ADDR_DBG)) begin
      protection_debug_ctrl <= reg_wdata & DBG_WRITE_MASK;
    end
  end

  // Control outputs taken from the debug bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      auth_timer_speedup         <= 1'b0;
      protect_master_fast_timing <= 1'b0;
      indirect_status_reg        <= 8'h00;
    end else begin
      auth_timer_speedup         <= protection_debug_ctrl[DBG_TIMER_BIT];
      protect_master_fast_timing <= protection_debug_ctrl[DBG_MASTER_FAST_BIT];
      indirect_status_reg        <= 8'h00;
      indirect_status_reg[IND_MASTER_FAST_BIT] <=
          protection_debug_ctrl[DBG_MASTER_FAST_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------

  // Read mux; unmapped offsets answer zero
  always_comb begin
    unique case (reg_addr)
      ADDR_CAPS:    next_rdata = rx_capability;
      ADDR_TOPO_LO: next_rdata = rx_topology_status_lo;
      ADDR_TOPO_HI: next_rdata = rx_topology_status_hi;
      ADDR_KEY:     next_rdata = key_rd_byte;
      ADDR_DBG:     next_rdata = protection_debug_ctrl;
      default:      next_rdata = 8'h00;
    endcase
  end

  // Data is answered one cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link verification schedule
  // ----------------------------------------------------------------------

  prsd_verify_sched u_verify_sched (
    .ref_clk            (ref_clk),
    .reset              (reset),
    .fast               (fast_link_verify),
    .frame_start        (frame_start),
    .frame_verify_due   (sched_fv),
    .link_integrity_due (sched_li)
  );

  // Registered again so top outputs come from local flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_verify_due   <= 1'b0;
      link_integrity_due <= 1'b0;
    end else begin
      frame_verify_due   <= sched_fv;
      link_integrity_due <= sched_li;
    end
  end

  // ----------------------------------------------------------------------
  // Per-line colour checksum
  // ----------------------------------------------------------------------

  // Sequencer: wait for a line, sum it, emit after its end
  always_comb begin
    unique case (ck_state)
      CK_IDLE: next_ck_state = video_de ? CK_LINE : CK_IDLE;
      CK_LINE: next_ck_state = video_de ? CK_LINE : CK_SEND;
      CK_SEND: next_ck_state = CK_IDLE;
      default: next_ck_state = CK_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ck_state <= CK_IDLE;
    end else begin
      ck_state <= next_ck_state;
    end
  end

  // One accumulator per channel; the first pixel of a line loads it.
  // A line that starts in CK_SEND loses its first pixel, so blanking must last
  // at least two cycles.
  for (genvar c = 0; c < 3; c++) begin : g_chan
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        ck_acc[c] <= 8'h00;
      end else if (video_de && (ck_state == CK_IDLE)) begin
        ck_acc[c] <= pix_ch[c];
      end else if (video_de && (ck_state == CK_LINE)) begin
        ck_acc[c] <= ones_add(ck_acc[c], pix_ch[c]);
      end
    end
  end

  // Checksum is sent only while enabled; it is the inverted sum
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      checksum_valid <= 1'b0;
      checksum_out   <= '0;
    end else begin
      checksum_valid <= 1'b0;
      if ((ck_state == CK_LINE) && !video_de && line_checksum_enable) begin
        checksum_valid <= 1'b1;
        checksum_out   <= ~ck_acc;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_line_end;
    ck_state == CK_LINE && !video_de;
  endsequence

  sequence s_dbg_write;
    reg_wr && reg_addr == ADDR_DBG;
  endsequence

  chk_caps_follow_link: assert property (
    status_valid |=> rx_capability[6:4] == $past({status_in.repeater,
      status_in.list_ready, status_in.fast_bus}) &&
      rx_capability[1:0] == $past({status_in.features, status_in.clear_reauth}))
    else $error("capability mirror does not follow link status");

  chk_reserved_zero: assert property (
    reg_rvalid && $past(reg_addr) == ADDR_CAPS |-> reg_rdata[7] == 1'b0 &&
      reg_rdata[3:2] == 2'b00)
    else $error("reserved capability bits read nonzero");

  chk_ro_write_ignored: assert property (
    reg_wr && !reg_rd && !status_valid && !key_list_start |=>
      $stable(rx_capability) && $stable(rx_topology_status_lo) &&
      $stable(key_rd_ptr))
    else $error("write altered read-only state");

  chk_count_nonrepeat: assert property (
    status_valid && !status_in.repeater |=> rx_topology_status_lo[6:0] == 7'h00)
    else $error("device count nonzero for plain receiver");

  chk_max_dev_flag: assert property (
    status_valid && status_in.repeater && status_in.dev_count > KEY_LIST_DEVICES
      |=> rx_topology_status_lo[TOPO_MAX_DEV_BIT])
    else $error("device overflow not flagged");

  chk_key_advance: assert property (
    key_rd_hit && !key_list_start && 32'(key_rd_ptr) < KEY_LIST_BYTES
      |=> key_rd_ptr == $past(key_rd_ptr) + 1'b1 && reg_rvalid &&
      reg_rdata == $past(key_rd_byte))
    else $error("key port read did not return byte and advance");

  chk_line_checksum: assert property (
    s_line_end ##0 line_checksum_enable |=> checksum_valid &&
      checksum_out == ~$past(ck_acc))
    else $error("line checksum missing or wrong");

  chk_no_checksum_off: assert property (
    !line_checksum_enable |=> !checksum_valid)
    else $error("checksum sent while disabled");

  chk_master_mirror: assert property (
    s_dbg_write |-> ##2 protect_master_fast_timing == $past(reg_wdata[0], 2) &&
      indirect_status_reg[IND_MASTER_FAST_BIT] == protect_master_fast_timing)
    else $error("master fast bit not applied or mirrored");

  chk_timer_speedup: assert property (
    s_dbg_write |-> ##2 auth_timer_speedup == $past(reg_wdata[1], 2))
    else $error("timer speedup not applied");

endmodule

// [sim/prsd_rx_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Downstream receiver model: status and key list over the link
// ----------------------------------------------------------------------
module prsd_rx_model
  import prsd_pkg::*;
(
  input  wire logic      ref_clk,
  output logic           status_valid,
  output prsd_rx_status_t status_in,
  output logic           key_list_start,
  output logic           key_byte_valid,
  output logic     [7:0] key_byte
);
  // Quiet link at time zero
  initial begin
    status_valid = 1'b0;
    status_in = '0;
    key_list_start = 1'b0;
    key_byte_valid = 1'b0;
    key_byte = 8'h00;
  end
  // One status update; idle value is inverted so stale data is never trusted
  task automatic send_status(input prsd_rx_status_t s);
    @(posedge ref_clk) status_in <= s;
    status_valid <= 1'b1;
    @(posedge ref_clk) status_valid <= 1'b0;
    status_in <= ~s;
  endtask
  // New key list of n bytes counting up from base
  task automatic send_list(input int n, input logic [7:0] base);
    @(posedge ref_clk) key_list_start <= 1'b1;
    @(posedge ref_clk) key_list_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      key_byte_valid <= 1'b1;
      key_byte <= base + 8'(i);
      @(posedge ref_clk);
    end
    key_byte_valid <= 1'b0;
    key_byte <= ~key_byte;
  endtask
endmodule

// [sim/prsd_status_regs_bench.sv]
`timescale 1ns/1ns
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
// ----------------------------------------------------------------------
// Self-checking bench for the status and debug registers
// ----------------------------------------------------------------------
module prsd_status_regs_bench;
  import prsd_pkg::*;
  logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, frame_start = 0, video_de = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, indirect_status_reg, key_byte;
  logic reg_rvalid, status_valid, key_list_start, key_byte_valid, checksum_valid;
  logic frame_verify_due, link_integrity_due, auth_timer_speedup, protect_master_fast_timing;
  prsd_rx_status_t status_in;
  prsd_pixel_t video_pixel = '0, checksum_out;
  int error_cnt = 0, tests_run = 0, nv = 0, ni = 0;
  prsd_status_regs i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .status_valid, .status_in, .key_list_start, .key_byte_valid,
    .key_byte, .frame_start, .video_de, .video_pixel, .checksum_valid, .checksum_out,
    .frame_verify_due, .link_integrity_due, .auth_timer_speedup,
    .protect_master_fast_timing, .indirect_status_reg);
  prsd_rx_model i_rx (.ref_clk, .status_valid, .status_in, .key_list_start,
    .key_byte_valid, .key_byte);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Due pulse tallies; scenarios take differences so no reset race arises
  always @(posedge ref_clk) begin
    nv <= nv + int'(frame_verify_due === 1'b1);
    ni <= ni + int'(link_integrity_due === 1'b1);
  end
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge ref_clk) reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask
  // Read and compare; answer must come within a bounded wait
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int i;
    @(posedge ref_clk) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(posedge ref_clk) #1;
    if (i == 4) begin
      error_cnt++;
      final_report();
    end else begin
      `CHK(reg_rdata, e)
    end
  endtask
  task automatic t_reset_vals();
    rd(ADDR_CAPS, 8'h13); rd(ADDR_TOPO_LO, 8'h00); rd(ADDR_TOPO_HI, 8'h00);
    rd(ADDR_KEY, 8'h00); rd(ADDR_DBG, 8'h00); rd(8'h55, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_status();
    i_rx.send_status({5'b11101, 1'b0, 7'h05, 1'b1, 3'h3});
    rd(ADDR_CAPS, 8'h71); rd(ADDR_TOPO_LO, 8'h05); rd(ADDR_TOPO_HI, 8'h0B);
    i_rx.send_status({5'b00010, 1'b0, 7'h05, 1'b0, 3'h0});
    rd(ADDR_CAPS, 8'h02); rd(ADDR_TOPO_LO, 8'h00); rd(ADDR_TOPO_HI, 8'h00);
    i_rx.send_status({5'b10000, 1'b0, 7'h11, 1'b0, 3'h7});
    wr(ADDR_TOPO_LO, 8'h00); wr(ADDR_CAPS, 8'hFF);
    rd(ADDR_CAPS, 8'h40); rd(ADDR_TOPO_LO, 8'h91); rd(ADDR_TOPO_HI, 8'h07);
    $display("status mirror done");
  endtask
  task automatic t_keys();
    i_rx.send_list(10, 8'hA0);
    for (int i = 0; i < 3; i++) rd(ADDR_KEY, 8'hA0 + 8'(i));
    wr(ADDR_KEY, 8'h5A);
    for (int i = 3; i < 10; i++) rd(ADDR_KEY, 8'hA0 + 8'(i));
    rd(ADDR_KEY, 8'h00);
    i_rx.send_list(5, 8'h30);
    rd(ADDR_KEY, 8'h30);
    $display("key list done");
  endtask
  task automatic t_debug();
    wr(ADDR_DBG, 8'hFF);
    rd(ADDR_DBG, 8'h0F);
    `CHK({auth_timer_speedup, protect_master_fast_timing, indirect_status_reg}, 10'h301)
    wr(ADDR_DBG, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK({auth_timer_speedup, protect_master_fast_timing, indirect_status_reg}, 10'h200)
    $display("debug controls done");
  endtask
  // Two-pixel line; with checksums on, expect ~ones-complement sum per channel
  task automatic line(input logic on);
    int i;
    @(posedge ref_clk) video_de <= 1'b1;
    video_pixel <= 24'h8001FF;
    @(posedge ref_clk) video_pixel <= 24'h900201;
    @(posedge ref_clk) video_de <= 1'b0;
    for (i = 0; i < 6 && checksum_valid !== 1'b1; i++) @(posedge ref_clk) #1;
    `CHK(i < 6, on)
    if (on) `CHK(checksum_out, 24'hEEFCFE)
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic frames(input int n, input int ev, input int ei);
    int v0 = nv, i0 = ni;
    repeat (n) begin
      @(posedge ref_clk) frame_start <= 1'b1;
      @(posedge ref_clk) frame_start <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    `CHK(nv - v0, ev)
    `CHK(ni - i0, ei)
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_vals(); t_status(); t_keys(); t_debug();
    line(1'b0);
    wr(ADDR_DBG, 8'h08);
    line(1'b1);
    do_reset(); frames(128, 8, 1);
    do_reset(); wr(ADDR_DBG, 8'h04); frames(32, 16, 2);
    $display("video and schedule done");
    final_report();
  end
endmodule
